// File: core/iabc_ctrl.sv
// Control slice of the two-wire serial interface: count, wait, acknowledge
// and interrupt gating. Assumes the shift path pulses the event inputs on
// clk and that scl and sda come straight from the pins.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "iabc_params.svh"
module iabc_ctrl #(
  parameter int WAIT_CYC = `IABC_WAIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       ev_tx_empty,
  input  wire logic       ev_tx_done,
  input  wire logic       ev_rx_full,
  input  wire logic       ev_arb_lost,
  input  wire logic       ev_overrun,
  output logic            lsb_first,
  output logic            xfer_halt,
  output logic            irq_tx_empty,
  output logic            irq_tx_done,
  output logic            irq_rx,
  output logic            irq_noack,
  output logic            irq_stop
);

  function automatic logic [3:0] bits_total(
    input logic [2:0] code,
    input logic       sync
  );
    logic [3:0] n;
    n = {1'b0, code};
    if (code == 3'h0)
    begin
      n = sync ? `IABC_BITS_SYNC0 : `IABC_BITS_I2C0;
    end
    else if (!sync)
    begin
      n = n + 4'h1;
    end
    return n;
  endfunction

  logic             scl_s1_r;
  logic             scl_s2_r;
  logic             scl_s3_r;
  logic             sda_s1_r;
  logic             sda_s2_r;
  logic             sda_s3_r;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic [2:0]       bit_count_field_r;
  logic             lsb_first_r;
  logic             wait_en_r;
  logic             rsv5_r;
  logic             tx_empty_irq_en_r;
  logic             tx_done_irq_en_r;
  logic             rx_full_irq_en_r;
  logic             noack_arb_irq_en_r;
  logic             end_condition_irq_en_r;
  logic             ack_check_en_r;
  logic             ack_in_value_r;
  logic             ack_out_value_r;
  logic             tx_empty_f_r;
  logic             tx_done_f_r;
  logic             rx_full_f_r;
  logic             no_ack_flag_r;
  logic             end_cond_f_r;
  logic             arb_ovr_f_r;
  logic             sync_fmt_r;
  logic             master_r;
  logic             transmit_r;
  logic [3:0]       bit_idx_r;
  logic             frame_seen_r;
  logic             last_bit;
  logic             ack_rise;
  logic             nak_ev;
  logic             wait_go;
  logic             bc_hw_clr;
  logic             wr_mode;
  logic             wr_ier;
  logic             wr_sr;
  logic             wr_ctrl;
  logic [15:0]      wait_cnt_r;
  iabc_pkg::iabc_link_t lk_state_r;
  logic [7:0]       rdata_r;
  logic             scl_oe_r;
  logic             sda_oe_r;
  logic             irq_tx_empty_r;
  logic             irq_tx_done_r;
  logic             irq_rx_r;
  logic             irq_noack_r;
  logic             irq_stop_r;
  logic             xfer_halt_r;

  // Pins are asynchronous; edges are found on the second and third stages.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end
    else
    begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  assign scl_rise  = scl_s2_r & ~scl_s3_r;
  assign scl_fall  = ~scl_s2_r & scl_s3_r;
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
  assign last_bit  = (bit_idx_r ==
                      bits_total(bit_count_field_r, sync_fmt_r) - 4'h1);
  assign ack_rise  = scl_rise & last_bit & ~sync_fmt_r & transmit_r;
  assign nak_ev    = ack_rise & sda_s2_r;
  assign wait_go   = scl_fall & last_bit & wait_en_r & master_r &
                     ~sync_fmt_r;
  assign bc_hw_clr = start_det | (scl_rise & last_bit);
  assign wr_mode   = wr & (addr == `IABC_ADDR_MODE);
  assign wr_ier    = wr & (addr == `IABC_ADDR_IER);
  assign wr_sr     = wr & (addr == `IABC_ADDR_SR);
  assign wr_ctrl   = wr & (addr == `IABC_ADDR_CTRL);

  // Mode register; the guard bit is never stored and reads as one.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_count_field_r <= 3'h0;
      lsb_first_r       <= 1'b0;
      wait_en_r         <= 1'b0;
      rsv5_r            <= 1'b0;
    end
    else
    begin
      if (bc_hw_clr)
      begin
        bit_count_field_r <= 3'h0;
      end
      else if (wr_mode && !wdata[`IABC_MD_GUARD])
      begin
        bit_count_field_r <= wdata[2:0];
      end
      if (wr_mode)
      begin
        lsb_first_r <= wdata[`IABC_MD_LSB];
        wait_en_r   <= wdata[`IABC_MD_WAIT];
        rsv5_r      <= wdata[`IABC_MD_RSV];
      end
    end
  end

  // Frame position: counts clock rises; in two-wire format the last one is the ack bit.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_idx_r    <= 4'h0;
      frame_seen_r <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      bit_idx_r    <= 4'h0;
      frame_seen_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      bit_idx_r    <= last_bit ? 4'h0 : bit_idx_r + 4'h1;
      frame_seen_r <= frame_seen_r | last_bit;
    end
    else if (wr_mode && !wdata[`IABC_MD_GUARD])
    begin
      bit_idx_r <= 4'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_empty_irq_en_r      <= 1'b0;
      tx_done_irq_en_r       <= 1'b0;
      rx_full_irq_en_r       <= 1'b0;
      noack_arb_irq_en_r     <= 1'b0;
      end_condition_irq_en_r <= 1'b0;
      ack_check_en_r         <= 1'b0;
      ack_out_value_r        <= 1'b0;
    end
    else if (wr_ier)
    begin
      tx_empty_irq_en_r      <= wdata[`IABC_IE_TXE];
      tx_done_irq_en_r       <= wdata[`IABC_IE_TXD];
      rx_full_irq_en_r       <= wdata[`IABC_IE_RXF];
      noack_arb_irq_en_r     <= wdata[`IABC_IE_NAK];
      end_condition_irq_en_r <= wdata[`IABC_IE_END];
      ack_check_en_r         <= wdata[`IABC_IE_CHK];
      ack_out_value_r        <= wdata[`IABC_IE_AOUT];
    end
  end

  // Only the line sets the captured ack; register writes skip it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_in_value_r <= 1'b0;
    end
    else if (ack_rise)
    begin
      ack_in_value_r <= sda_s2_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_fmt_r <= 1'b0;
      master_r   <= 1'b0;
      transmit_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sync_fmt_r <= wdata[`IABC_CT_SYNC];
      master_r   <= wdata[`IABC_CT_MST];
      transmit_r <= wdata[`IABC_CT_TX];
    end
  end

  // Flags clear on a written 0; an event in the same cycle wins.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_empty_f_r  <= 1'b0;
      tx_done_f_r   <= 1'b0;
      rx_full_f_r   <= 1'b0;
      no_ack_flag_r <= 1'b0;
      end_cond_f_r  <= 1'b0;
      arb_ovr_f_r   <= 1'b0;
    end
    else
    begin
      tx_empty_f_r  <= ev_tx_empty |
        (tx_empty_f_r & ~(wr_sr & ~wdata[`IABC_SR_TXE]));
      tx_done_f_r   <= ev_tx_done |
        (tx_done_f_r & ~(wr_sr & ~wdata[`IABC_SR_TXD]));
      rx_full_f_r   <= ev_rx_full |
        (rx_full_f_r & ~(wr_sr & ~wdata[`IABC_SR_RXF]));
      no_ack_flag_r <= nak_ev |
        (no_ack_flag_r & ~(wr_sr & ~wdata[`IABC_SR_NAK]));
      end_cond_f_r  <= (stop_det & frame_seen_r) |
        (end_cond_f_r & ~(wr_sr & ~wdata[`IABC_SR_END]));
      arb_ovr_f_r   <= (ev_arb_lost & ~sync_fmt_r) |
        (ev_overrun & sync_fmt_r) |
        (arb_ovr_f_r & ~(wr_sr & ~wdata[`IABC_SR_ARB]));
    end
  end

  // Clock stretch and halt; the halt holds the clock only as master.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lk_state_r <= iabc_pkg::LK_RUN;
      wait_cnt_r <= 16'h0000;
    end
    else
    begin
      unique case (lk_state_r)
        iabc_pkg::LK_RUN:
        begin
          if (ack_rise && ack_check_en_r && sda_s2_r)
          begin
            lk_state_r <= iabc_pkg::LK_HALT;
          end
          else if (wait_go)
          begin
            lk_state_r <= iabc_pkg::LK_WAIT;
            wait_cnt_r <= WAIT_CYC[15:0] - 16'h0001;
          end
        end
        iabc_pkg::LK_WAIT:
        begin
          if (wait_cnt_r == 16'h0000)
          begin
            lk_state_r <= iabc_pkg::LK_RUN;
          end
          else
          begin
            wait_cnt_r <= wait_cnt_r - 16'h0001;
          end
        end
        iabc_pkg::LK_HALT:
        begin
          if (start_det || wr_ctrl)
          begin
            lk_state_r <= iabc_pkg::LK_RUN;
          end
        end
        default:
        begin
          lk_state_r <= iabc_pkg::LK_RUN;
        end
      endcase
    end
  end

  // Registered so the halt pin never shows a decode glitch; one cycle late.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xfer_halt_r <= 1'b0;
    end
    else
    begin
      xfer_halt_r <= (lk_state_r == iabc_pkg::LK_HALT);
    end
  end

  // Open-drain drive: enable high pulls the line low.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      scl_oe_r <= wait_go |
        ((lk_state_r == iabc_pkg::LK_WAIT) && (wait_cnt_r != 16'h0000)) |
        ((lk_state_r == iabc_pkg::LK_HALT) && master_r);
      if (start_det || stop_det)
      begin
        sda_oe_r <= 1'b0;
      end
      else if (scl_fall)
      begin
        sda_oe_r <= last_bit & ~sync_fmt_r & ~transmit_r &
                    ~ack_out_value_r;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_tx_empty_r <= 1'b0;
      irq_tx_done_r  <= 1'b0;
      irq_rx_r       <= 1'b0;
      irq_noack_r    <= 1'b0;
      irq_stop_r     <= 1'b0;
    end
    else
    begin
      irq_tx_empty_r <= tx_empty_f_r & tx_empty_irq_en_r;
      irq_tx_done_r  <= tx_done_f_r & tx_done_irq_en_r;
      irq_rx_r       <= (rx_full_f_r | (arb_ovr_f_r & sync_fmt_r)) &
                        rx_full_irq_en_r;
      irq_noack_r    <= (no_ack_flag_r | arb_ovr_f_r) &
                        noack_arb_irq_en_r;
      irq_stop_r     <= end_cond_f_r & end_condition_irq_en_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 8'h00;
    end
    else if (!rd)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      unique case (addr)
        `IABC_ADDR_MODE: rdata_r <= {lsb_first_r, wait_en_r, rsv5_r,
                                     2'b11, bit_count_field_r};
        `IABC_ADDR_IER:  rdata_r <= {tx_empty_irq_en_r, tx_done_irq_en_r,
                                     rx_full_irq_en_r, noack_arb_irq_en_r,
                                     end_condition_irq_en_r, ack_check_en_r,
                                     ack_in_value_r, ack_out_value_r};
        `IABC_ADDR_SR:   rdata_r <= {tx_empty_f_r, tx_done_f_r, rx_full_f_r,
                                     no_ack_flag_r, end_cond_f_r,
                                     arb_ovr_f_r, 2'b00};
        `IABC_ADDR_CTRL: rdata_r <= {5'h00, transmit_r, master_r,
                                     sync_fmt_r};
        default:         rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata        = rdata_r;
  assign scl_o        = 1'b0;
  assign sda_o        = 1'b0;
  assign scl_oe       = scl_oe_r;
  assign sda_oe       = sda_oe_r;
  assign lsb_first    = lsb_first_r;
  assign xfer_halt    = xfer_halt_r;
  assign irq_tx_empty = irq_tx_empty_r;
  assign irq_tx_done  = irq_tx_done_r;
  assign irq_rx       = irq_rx_r;
  assign irq_noack    = irq_noack_r;
  assign irq_stop     = irq_stop_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_guard_keeps_count: assert property (
    wr_mode && wdata[`IABC_MD_GUARD] && !bc_hw_clr |=>
    $stable(bit_count_field_r)) else $error("guarded count changed");
  a_count_takes_write: assert property (
    wr_mode && !wdata[`IABC_MD_GUARD] && !bc_hw_clr |=>
    bit_count_field_r == $past(wdata[2:0])) else $error("count lost");
  a_count_clears: assert property (
    bc_hw_clr |=> bit_count_field_r == 3'h0) else $error("count kept");
  a_wait_only_master: assert property (
    scl_fall && last_bit && !(master_r && !sync_fmt_r) &&
    lk_state_r == iabc_pkg::LK_RUN |=> lk_state_r != iabc_pkg::LK_WAIT)
    else $error("wait outside master");
  a_wait_length: assert property (
    wait_go && lk_state_r == iabc_pkg::LK_RUN |=> scl_oe_r[*8] ##17
    scl_oe_r ##1 !scl_oe_r) else $error("wait length wrong");
  a_ack_drive: assert property (
    scl_fall && last_bit && !sync_fmt_r && !transmit_r && !start_det &&
    !stop_det |=> sda_oe_r == !$past(ack_out_value_r))
    else $error("ack drive wrong");
  a_ack_capture: assert property (
    ack_rise |=> ack_in_value_r == $past(sda_s2_r))
    else $error("ack not captured");
  a_halt_on_nak: assert property (
    ack_rise && sda_s2_r && ack_check_en_r &&
    lk_state_r == iabc_pkg::LK_RUN |=> ##[0:1] xfer_halt)
    else $error("no halt on nak");
  a_stop_gate: assert property (
    !end_condition_irq_en_r |=> !irq_stop_r) else $error("stop leaked");
  a_nak_gate: assert property (
    (no_ack_flag_r || arb_ovr_f_r) && noack_arb_irq_en_r |=> irq_noack_r)
    else $error("noack request missing");
  a_rx_gate: assert property (
    !rx_full_irq_en_r |=> !irq_rx_r) else $error("rx leaked");
  a_tx_done_gate: assert property (
    tx_done_f_r && tx_done_irq_en_r |=> irq_tx_done_r)
    else $error("tx done missing");
  a_tx_empty_gate: assert property (
    !tx_empty_irq_en_r |=> !irq_tx_empty_r) else $error("tx empty leaked");
  a_ovr_sync_only: assert property (
    ev_overrun && !ev_arb_lost && !sync_fmt_r && !arb_ovr_f_r |=>
    !arb_ovr_f_r) else $error("overrun outside sync");
  a_stop_flag_set: assert property (
    stop_det && frame_seen_r |=> end_cond_f_r) else $error("stop flag");
  a_nak_flag_set: assert property (
    nak_ev |=> no_ack_flag_r) else $error("nak flag not set");
  a_ack_in_ro: assert property (
    wr_ier && !ack_rise |=> $stable(ack_in_value_r))
    else $error("ack in written");

  c_wait_seen: cover property (wait_go ##1 scl_oe_r);
  c_halt_seen: cover property ($rose(xfer_halt));
  c_stop_flag: cover property (stop_det && frame_seen_r);
  c_ack_drive: cover property ($rose(sda_oe_r));

endmodule
`default_nettype wire

// File: core/iabc_params.svh
// Constants of the two-wire control slice: offsets, fields, resets, times.
// Assumes the includer uses 8-bit register data and a 100 MHz clock.
// Overview of operation
// - The bit count takes a write only when the same write clears the guard.
// - Bit count returns to zero after the last bit of each frame (the acknowledge in two-wire format), and on start.
// - Wait insertion acts only as two-wire bus master.
// - In receive mode the acknowledge bit sent is the ack output value.
// - In transmit mode the returned acknowledge is captured into a status bit.
// - With ack checking on, a received 1 halts continuous transfer.
// - The stop condition request passes only while its enable is 1.
// - One enable gates no-acknowledge and arbitration lost or overrun requests.
// - Receive enable gates receive full and overrun requests.
// - Transmit end request passes only while its enable is 1.
// - Transmit empty request is suppressed while its enable is 0.
// - Overrun error request arises only in clock synchronous format.
// - Count code 000b means 9 bits two-wire and 8 sync; codes 001b to 111b mean 2 to 8 two-wire and 1 to 7 sync.
// - Wait holds the clock low two transfer clocks after the last data bit.
// - Stop flag sets when a stop follows a transferred frame.
// - No-acknowledge flag sets when the receiver returns no acknowledge.
`ifndef IABC_PARAMS_SVH
`define IABC_PARAMS_SVH
`define IABC_ADDR_MODE   8'hba
`define IABC_ADDR_IER    8'hbb
`define IABC_ADDR_SR     8'hbc
`define IABC_ADDR_CTRL   8'hbd
`define IABC_MD_LSB      7
`define IABC_MD_WAIT     6
`define IABC_MD_RSV      5
`define IABC_MD_GUARD    3
`define IABC_IE_TXE      7
`define IABC_IE_TXD      6
`define IABC_IE_RXF      5
`define IABC_IE_NAK      4
`define IABC_IE_END      3
`define IABC_IE_CHK      2
`define IABC_IE_AIN      1
`define IABC_IE_AOUT     0
`define IABC_SR_TXE      7
`define IABC_SR_TXD      6
`define IABC_SR_RXF      5
`define IABC_SR_NAK      4
`define IABC_SR_END      3
`define IABC_SR_ARB      2
`define IABC_CT_SYNC     0
`define IABC_CT_MST      1
`define IABC_CT_TX       2
`define IABC_MODE_ONES   8'h18
`define IABC_BITS_I2C0   4'h9
`define IABC_BITS_SYNC0  4'h8
`define IABC_CLK_NS      10
`define IABC_LINK_NS     125
`define IABC_WAIT_XCLK   2
`define IABC_WAIT_CYC    ((`IABC_WAIT_XCLK*`IABC_LINK_NS+`IABC_CLK_NS-1)/`IABC_CLK_NS)
`endif

// File: core/iabc_pkg.sv
// Types of the two-wire control slice.
// Assumes the constants header is included by the modules that use it.
package iabc_pkg;
  typedef enum logic [1:0] {
    LK_RUN  = 2'b00,
    LK_WAIT = 2'b01,
    LK_HALT = 2'b10
  } iabc_link_t;
endpackage

// File: testbench/iabc_ctrl_tb.sv
// Bench for the two-wire control slice: registers, link and request gating.
// Assumes one peer model on pulled-up lines and the default wait length.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
  begin \
    total_checks++; \
    if ((s) !== (e)) \
    begin \
      fail_count++; \
      $display("[ERR] %s exp %h got %h", n, e, s); \
    end \
  end
module iabc_ctrl_tb;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        p_scl;
  logic        p_sda;
  logic [8:0]  seen;
  logic [4:0]  ev;
  logic [4:0]  irq;
  logic        xfer_halt;
  logic        ak;
  logic [7:0]  ie;
  logic [7:0]  oe_run;
  logic [7:0]  oe_max;
  logic        oe_clr;
  logic        lsb;
  logic [18:0] tab [8];
  int          fail_count;
  int          total_checks;
  wire         scl = !(scl_oe || p_scl);
  wire         sda = !(sda_oe || p_sda);
  iabc_ctrl uut (
    .clk          (clk),
    .rst          (rst),
    .addr         (addr),
    .wdata        (wdata),
    .wr           (wr),
    .rd           (rd),
    .rdata        (rdata),
    .scl_i        (scl),
    .sda_i        (sda),
    .scl_o        (),
    .scl_oe       (scl_oe),
    .sda_o        (),
    .sda_oe       (sda_oe),
    .ev_tx_empty  (ev[4]),
    .ev_tx_done   (ev[3]),
    .ev_rx_full   (ev[2]),
    .ev_arb_lost  (ev[1]),
    .ev_overrun   (ev[0]),
    .lsb_first    (lsb),
    .xfer_halt    (xfer_halt),
    .irq_tx_empty (irq[4]),
    .irq_tx_done  (irq[3]),
    .irq_rx       (irq[2]),
    .irq_noack    (irq[1]),
    .irq_stop     (irq[0])
  );
  iabc_peer peer (
    .scl    (scl),
    .sda    (sda),
    .scl_dn (p_scl),
    .sda_dn (p_sda),
    .seen   (seen)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // Longest run of the stretched clock, for the wait length test.
  always @(posedge clk)
  begin
    if (oe_clr)
    begin
      oe_run <= 8'h00;
      oe_max <= 8'h00;
    end
    else
    begin
      oe_run <= scl_oe ? oe_run + 8'h01 : 8'h00;
      if (oe_run > oe_max)
        oe_max <= oe_run;
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] a,
                         input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(n, e, rdata)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Entries: sync format, enables, event pulse, expected requests.
  initial
  begin
    tab = '{{1'b0, 8'h00, 5'h10, 5'h00}, {1'b0, 8'h80, 5'h10, 5'h10},
           {1'b0, 8'h00, 5'h08, 5'h00}, {1'b0, 8'h40, 5'h08, 5'h08},
           {1'b0, 8'h20, 5'h04, 5'h04}, {1'b0, 8'h10, 5'h02, 5'h02},
           {1'b0, 8'h30, 5'h01, 5'h00}, {1'b1, 8'h30, 5'h01, 5'h06}};
  end
  // Frames take about 2 us each, so this leaves a wide margin.
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ev = 5'h00;
    oe_clr = 1'b1;
    fail_count = 0;
    total_checks = 0;
    peer.idle();
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    oe_clr <= 1'b0;
    chk_reg("mode", 8'hba, 8'h18);
    chk_reg("ier", 8'hbb, 8'h00);
    chk_reg("flags", 8'hbc, 8'h00);
    chk_reg("unmapped", 8'h00, 8'h00);
    $display("test reset done");
    wr_reg(8'hba, 8'h8d);
    chk_reg("guarded", 8'hba, 8'h98);
    `CHK("lsb first", 1'b1, lsb)
    peer.start();
    wr_reg(8'hba, 8'h03);
    chk_reg("count", 8'hba, 8'h1b);
    peer.frame(4, 9'h000);
    chk_reg("count end", 8'hba, 8'h18);
    wr_reg(8'hba, 8'h03);
    peer.start();
    chk_reg("count start", 8'hba, 8'h18);
    peer.stop();
    $display("test count done");
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'hbc, 8'h00);
      wr_reg(8'hbb, i ? 8'h09 : 8'h00);
      peer.start();
      peer.frame(9, 9'h14b);
      `CHK("ack sent", i[0], seen[0])
      peer.stop();
      repeat (8) @(posedge clk);
      chk_reg("stop flag", 8'hbc, 8'h08);
      `CHK("stop irq", i[0], irq[0])
    end
    $display("test receive done");
    // The control write at the top also lifts a halt left by the last pass.
    for (int i = 0; i < 3; i++)
    begin
      ak = (i < 2);
      ie = (i == 0) ? 8'h10 : 8'h14;
      wr_reg(8'hbc, 8'h00);
      wr_reg(8'hbd, 8'h04);
      wr_reg(8'hbb, ie);
      peer.start();
      peer.frame(9, {8'h00, ak});
      repeat (6) @(posedge clk);
      wr_reg(8'hbb, ie | {6'h00, !ak, 1'b0});
      chk_reg("ack seen", 8'hbb, ie | {6'h00, ak, 1'b0});
      chk_reg("nack flag", 8'hbc, {3'h0, ak, 4'h0});
      `CHK("nack irq", ak, irq[1])
      `CHK("halt", ak & ie[2], xfer_halt)
      peer.stop();
    end
    $display("test transmit done");
    wr_reg(8'hbb, 8'h00);
    wr_reg(8'hba, 8'h40);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(8'hbd, (i == 0) ? 8'h02 : (i == 1) ? 8'h00 : 8'h03);
      oe_clr <= 1'b1;
      @(posedge clk);
      oe_clr <= 1'b0;
      peer.start();
      peer.frame(9, 9'h0ff);
      peer.stop();
      `CHK("wait len", (i == 0) ? 8'h19 : 8'h00, oe_max)
    end
    $display("test wait done");
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(8'hbc, 8'h00);
      wr_reg(8'hbd, {7'h00, tab[i][18]});
      wr_reg(8'hbb, tab[i][17:10]);
      @(posedge clk);
      ev <= tab[i][9:5];
      @(posedge clk);
      ev <= 5'h00;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("irq", tab[i][4:0], irq)
    end
    $display("test requests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: testbench/iabc_peer.sv
// Peer on the two-wire bus: makes start, stop, clocked bits and acknowledges.
// Assumes pulled-up lines that the bench resolves from both parties' pulls.
`timescale 1ns/1ps
`default_nettype none
module iabc_peer (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_dn,
  output logic            sda_dn,
  output logic      [8:0] seen
);
  // Both lines released; the bench calls this once while reset is held.
  task automatic idle();
    scl_dn = 1'b0;
    sda_dn = 1'b0;
    seen = 9'h000;
  endtask
  // Also serves as a repeated start, since it first releases both lines.
  task automatic start();
    sda_dn = 1'b0;
    #62.5;
    scl_dn = 1'b0;
    #62.5;
    sda_dn = 1'b1;
    #62.5;
    scl_dn = 1'b1;
    #62.5;
  endtask
  // Data only changes while the clock is low; a stretched clock is waited out.
  task automatic bit_x(input logic b, output logic s);
    sda_dn = !b;
    #62.5;
    scl_dn = 1'b0;
    wait (scl === 1'b1);
    #31;
    s = sda;
    #31.5;
    scl_dn = 1'b1;
  endtask
  // The clock stands low between frames instead of running free.
  task automatic frame(input int n, input logic [8:0] d);
    for (int i = n - 1; i >= 0; i--)
      bit_x(d[i], seen[i]);
  endtask
  task automatic stop();
    sda_dn = 1'b1;
    #62.5;
    scl_dn = 1'b0;
    #62.5;
    sda_dn = 1'b0;
    #62.5;
  endtask
endmodule
`default_nettype wire
